// [core/pdfs_pkg.sv]
package pdfs_pkg;

	// ==========================================================
	// register map and field layout
	localparam logic [7:0]  PDFS_ADDR_UPPER  = 8'h00;
	localparam logic [7:0]  PDFS_ADDR_LOWER  = 8'h04;
	localparam logic [7:0]  PDFS_ADDR_STATUS = 8'h08;
	localparam logic [15:0] PDFS_UPPER_RST   = 16'h0000;
	localparam logic [15:0] PDFS_LOWER_RST   = 16'h0000;
	localparam int          PDFS_FIELD_W     = 2;
	localparam int          PDFS_NUM_UPPER   = 8;
	localparam int          PDFS_NUM_LOWER   = 16;
	localparam int          PDFS_NUM_PINS    = 24;

	// ==========================================================
	// field encodings of the upper select register
	localparam logic [1:0] PDFS_FUNC_GPIO = 2'h0;
	localparam logic [1:0] PDFS_FUNC_BUS  = 2'h1;
	localparam logic [1:0] PDFS_FUNC_IRQ  = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PDFS_MODE_SINGLE,
		PDFS_MODE_EXT_ROM,
		PDFS_MODE_EXT_NOROM
	} pdfs_mode_t;

	typedef enum logic [1:0] {
		PDFS_SEL_GPIO,
		PDFS_SEL_BUS,
		PDFS_SEL_IRQ
	} pdfs_sel_t;

	// drive of all 24 port pins: output level and output enable
	typedef struct packed {
		logic [23:0] dout;
		logic [23:0] oe;
	} pdfs_pad_t;

	typedef struct packed {
		logic [15:0] upper_reg;
		logic [15:0] lower_reg;
		logic [15:0] rdata;
		pdfs_pad_t   pad;
		logic [23:0] gpio_in;
		logic [23:0] bus_in;
		logic [7:0]  irq;
		logic [7:0]  bus_sel_up;
		logic [7:0]  irq_sel;
	} pdfs_state_t;

endpackage

// [core/pdfs_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pdfs_top (
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	input  wire logic             manual_rst_i,
	input  wire pdfs_pkg::pdfs_mode_t op_mode_i,
	input  wire logic             cs0_bus32_i,
	input  wire logic [7:0]       addr_i,
	input  wire logic [15:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic [15:0]           rdata_o,
	input  wire logic [23:0]      pad_in_i,
	output pdfs_pkg::pdfs_pad_t   pad_o,
	input  wire pdfs_pkg::pdfs_pad_t gpio_drv_i,
	input  wire pdfs_pkg::pdfs_pad_t bus_drv_i,
	output logic [23:0]           gpio_in_o,
	output logic [23:0]           bus_in_o,
	output logic [7:0]            irq_o
);
	import pdfs_pkg::*;

	typedef enum logic [1:0] {
		PDFS_REG_NONE,
		PDFS_REG_UPPER,
		PDFS_REG_LOWER,
		PDFS_REG_STATUS
	} pdfs_reg_t;

	pdfs_state_t s_reg;
	pdfs_state_t s_next;
	pdfs_sel_t   sel [PDFS_NUM_PINS];
	pdfs_reg_t   hit;

	localparam pdfs_state_t PDFS_STATE_RST = '{
		upper_reg: PDFS_UPPER_RST,
		lower_reg: PDFS_LOWER_RST,
		default:   '0
	};

	// ==========================================================
	// function decoding

	// exact match on the full byte address, so aliases read as unmapped
	function automatic pdfs_reg_t reg_decode(input logic [7:0] a);
		pdfs_reg_t r;
		r = PDFS_REG_NONE;
		if (a == PDFS_ADDR_UPPER) begin
			r = PDFS_REG_UPPER;
		end else if (a == PDFS_ADDR_LOWER) begin
			r = PDFS_REG_LOWER;
		end else if (a == PDFS_ADDR_STATUS) begin
			r = PDFS_REG_STATUS;
		end
		return r;
	endfunction

	assign hit = reg_decode(addr_i);

	function automatic pdfs_sel_t upper_sel(input logic [1:0] f, input pdfs_mode_t m,
		input logic cs32);
		pdfs_sel_t r;
		r = PDFS_SEL_GPIO;
		case (f)
			PDFS_FUNC_GPIO: begin
				if (m == PDFS_MODE_EXT_NOROM && cs32) begin
					r = PDFS_SEL_BUS;
				end
			end
			PDFS_FUNC_BUS: begin
				if (m != PDFS_MODE_SINGLE) begin
					r = PDFS_SEL_BUS;
				end
			end
			PDFS_FUNC_IRQ: begin
				r = PDFS_SEL_IRQ;
			end
			default: begin
				r = PDFS_SEL_GPIO;
			end
		endcase
		return r;
	endfunction

	function automatic pdfs_sel_t lower_sel(input logic b, input pdfs_mode_t m);
		pdfs_sel_t r;
		r = PDFS_SEL_GPIO;
		case (m)
			PDFS_MODE_EXT_NOROM: begin
				r = PDFS_SEL_BUS;
			end
			PDFS_MODE_EXT_ROM: begin
				r = b ? PDFS_SEL_BUS : PDFS_SEL_GPIO;
			end
			// single chip keeps the stored bits but never uses them
			default: begin
				r = PDFS_SEL_GPIO;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// per-pin selection from the stored registers
	genvar gi;
	generate
		for (gi = 0; gi < PDFS_NUM_LOWER; gi++) begin : g_low
			assign sel[gi] = lower_sel(s_reg.lower_reg[gi], op_mode_i);
		end
		for (gi = 0; gi < PDFS_NUM_UPPER; gi++) begin : g_up
			assign sel[PDFS_NUM_LOWER + gi] = upper_sel(
				s_reg.upper_reg[PDFS_FIELD_W*gi +: PDFS_FIELD_W], op_mode_i, cs0_bus32_i);
		end
	endgenerate

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.rdata = '0;

		// register writes; status is read only
		if (wr_i) begin
			if (hit == PDFS_REG_UPPER) begin
				s_next.upper_reg = wdata_i;
			end else if (hit == PDFS_REG_LOWER) begin
				s_next.lower_reg = wdata_i;
			end
		end

		// manual or watchdog reset keeps lower
		// placed after the write so the reset wins a same-cycle write
		if (manual_rst_i) begin
			s_next.upper_reg = PDFS_UPPER_RST;
		end

		// unmapped reads return zero, the slave never stalls
		// status reports the registered selection, one cycle behind the registers
		if (rd_i) begin
			if (hit == PDFS_REG_UPPER) begin
				s_next.rdata = s_reg.upper_reg;
			end else if (hit == PDFS_REG_LOWER) begin
				s_next.rdata = s_reg.lower_reg;
			end else if (hit == PDFS_REG_STATUS) begin
				s_next.rdata = {s_reg.bus_sel_up, s_reg.irq_sel};
			end
		end

		// drive requests of the selected owner pass through; irq pins are never driven; the owning logic decides direction

		for (int i = 0; i < PDFS_NUM_PINS; i++) begin
			s_next.pad.dout[i] = gpio_drv_i.dout[i];
			s_next.pad.oe[i]   = gpio_drv_i.oe[i];
			s_next.gpio_in[i]  = pad_in_i[i];
			s_next.bus_in[i]   = 1'b0;
			if (sel[i] == PDFS_SEL_BUS) begin
				s_next.pad.dout[i] = bus_drv_i.dout[i];
				s_next.pad.oe[i]   = bus_drv_i.oe[i];
				s_next.gpio_in[i]  = 1'b0;
				s_next.bus_in[i]   = pad_in_i[i];
			end else if (sel[i] == PDFS_SEL_IRQ) begin
				s_next.pad.dout[i] = 1'b0;
				s_next.pad.oe[i]   = 1'b0;
				s_next.gpio_in[i]  = 1'b0;
			end
		end

		for (int k = 0; k < PDFS_NUM_UPPER; k++) begin
			// forward sampled level
			// level only: edge detection belongs to the interrupt controller
			if (sel[PDFS_NUM_LOWER + k] == PDFS_SEL_IRQ) begin
				s_next.irq[k] = pad_in_i[PDFS_NUM_LOWER + k];
			end else begin
				s_next.irq[k] = 1'b0;
			end
			s_next.irq_sel[k]    = (sel[PDFS_NUM_LOWER + k] == PDFS_SEL_IRQ);
			s_next.bus_sel_up[k] = (sel[PDFS_NUM_LOWER + k] == PDFS_SEL_BUS);
		end
	end

	// ==========================================================
	// state register; reset_n_i is the external power-on reset
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			s_reg <= PDFS_STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs, each taken straight from the state register
	assign rdata_o   = s_reg.rdata;
	assign pad_o     = s_reg.pad;
	assign gpio_in_o = s_reg.gpio_in;
	assign bus_in_o  = s_reg.bus_in;
	assign irq_o     = s_reg.irq;

endmodule
`default_nettype wire

// [sim/pdfs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pdfs_chk (
	input wire logic                 mclk_i,
	input wire logic                 reset_n_i,
	input wire logic                 manual_rst_i,
	input wire pdfs_pkg::pdfs_mode_t op_mode_i,
	input wire logic [7:0]           addr_i,
	input wire logic [15:0]          wdata_i,
	input wire logic                 wr_i,
	input wire logic                 rd_i,
	input wire logic [15:0]          rdata_o,
	input wire logic [23:0]          pad_in_i,
	input wire pdfs_pkg::pdfs_pad_t  pad_o,
	input wire logic [23:0]          gpio_in_o,
	input wire logic [23:0]          bus_in_o,
	input wire logic [7:0]           irq_o
);
	import pdfs_pkg::*;
	// ==========
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
		else $error("read data out of slot");
	a_lower_kept: assert property ((wr_i && addr_i == PDFS_ADDR_LOWER) ##1
		(rd_i && addr_i == PDFS_ADDR_LOWER) |=> rdata_o == $past(wdata_i, 2)) else $error("lower lost");
	a_manual_clr: assert property (manual_rst_i ##1 (rd_i && addr_i == PDFS_ADDR_UPPER)
		|=> rdata_o == 16'h0) else $error("upper not cleared");
	a_irq_drv_off: assert property ((irq_o & (pad_o.oe[23:16] | pad_o.dout[23:16])) == 8'h0)
		else $error("irq pin driven");
	a_irq_level: assert property ($past(reset_n_i) |->
		(irq_o & ~$past(pad_in_i[23:16])) == 8'h0) else $error("irq not pin level");
	a_path_excl: assert property ((gpio_in_o & bus_in_o) == 24'h0 &&
		(irq_o & (gpio_in_o[23:16] | bus_in_o[23:16])) == 8'h0) else $error("pin on two paths");
	a_single_gpio: assert property ($past(reset_n_i) && $past(op_mode_i) == PDFS_MODE_SINGLE
		|-> bus_in_o == 24'h0 && gpio_in_o[15:0] == $past(pad_in_i[15:0])) else $error("single");
	a_norom_bus: assert property ($past(reset_n_i) && $past(op_mode_i) == PDFS_MODE_EXT_NOROM
		|-> bus_in_o[15:0] == $past(pad_in_i[15:0]) && gpio_in_o[15:0] == 16'h0) else $error("norom");
endmodule
bind pdfs_top pdfs_chk u_chk (.mclk_i, .reset_n_i, .manual_rst_i, .op_mode_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .pad_in_i, .pad_o, .gpio_in_o, .bus_in_o, .irq_o);
`default_nettype wire

// [sim/test_port_d_upper_pin_function_select.sv]
`timescale 1ns/1ps
`default_nettype none
module test_port_d_upper_pin_function_select;
	import pdfs_pkg::*;
	typedef struct packed {
		pdfs_mode_t  m;
		logic        c;
		logic [15:0] u;
		logic [15:0] l;
		logic [23:0] g;
		logic [23:0] b;
		logic [7:0]  q;
	} pdfs_row_t;
	logic        mclk_i, reset_n_i, manual_rst_i, cs0_bus32_i, wr_i, rd_i;
	pdfs_mode_t  op_mode_i;
	logic [7:0]  addr_i, irq_o;
	logic [15:0] wdata_i, rdata_o;
	logic [23:0] pad_in_i, gpio_in_o, bus_in_o;
	pdfs_pad_t   pad_o, gpio_drv_i, bus_drv_i;
	int          n_mismatch, comparisons;
	int          cyc = 0;
	// rows: mode, cs0 32-bit, upper, lower, expected gpio_in, bus_in, irq with all pins high
	pdfs_row_t   rows [5] = '{
		'{PDFS_MODE_SINGLE, 1'b1, 16'h1b1b, 16'h00ff, 24'hddffff, 24'h000000, 8'h22},
		'{PDFS_MODE_EXT_ROM, 1'b1, 16'h1b1b, 16'h00ff, 24'h99ff00, 24'h4400ff, 8'h22},
		'{PDFS_MODE_EXT_NOROM, 1'b1, 16'h1b1b, 16'h00ff, 24'h110000, 24'hccffff, 8'h22},
		'{PDFS_MODE_EXT_NOROM, 1'b0, 16'h1b1b, 16'h00ff, 24'h990000, 24'h44ffff, 8'h22},
		'{PDFS_MODE_EXT_ROM, 1'b0, 16'he4e4, 16'h0f0f, 24'h99f0f0, 24'h220f0f, 8'h44}};
	pdfs_top DUT (.mclk_i, .reset_n_i, .manual_rst_i, .op_mode_i, .cs0_bus32_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .pad_in_i, .pad_o, .gpio_drv_i, .bus_drv_i, .gpio_in_o, .bus_in_o,
		.irq_o);
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// ==========
	// tasks
	task end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// lowers a pending write strobe too, so a write may run straight into a read
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk_i);
		wr_i <= 1'b0;
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", {8'h0, e}, {8'h0, rdata_o});
	endtask
	// timeout: the run needs about 76 cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		{manual_rst_i, cs0_bus32_i, wr_i, rd_i, reset_n_i, addr_i, wdata_i} = '0;
		{n_mismatch, comparisons} = '0;
		op_mode_i = PDFS_MODE_EXT_ROM;
		pad_in_i = '1;
		gpio_drv_i = '{dout: '1, oe: '1};
		bus_drv_i = '{dout: '0, oe: '1};
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd(PDFS_ADDR_UPPER, 16'h0);
		rd(PDFS_ADDR_LOWER, 16'h0);
		foreach (rows[i]) begin
			@(posedge mclk_i);
			op_mode_i <= rows[i].m;
			cs0_bus32_i <= rows[i].c;
			wr(PDFS_ADDR_UPPER, rows[i].u);
			wr(PDFS_ADDR_LOWER, rows[i].l);
			repeat (2) @(posedge mclk_i);
			#1 chk("gpio_in", rows[i].g, gpio_in_o);
			chk("bus_in", rows[i].b, bus_in_o);
			chk("irq", {16'h0, rows[i].q}, {16'h0, irq_o});
			chk("oe", rows[i].g | rows[i].b, pad_o.oe);
			chk("dout", rows[i].g, pad_o.dout);
			rd(PDFS_ADDR_UPPER, rows[i].u);
			rd(PDFS_ADDR_STATUS, {rows[i].b[23:16], rows[i].q});
			$display("row %0d done", i);
		end
		@(posedge mclk_i);
		pad_in_i <= 24'h0;
		repeat (2) @(posedge mclk_i);
		#1 chk("irq low", 24'h0, {16'h0, irq_o});
		@(posedge mclk_i);
		addr_i <= PDFS_ADDR_LOWER;
		wdata_i <= 16'h1234;
		wr_i <= 1'b1;
		manual_rst_i <= 1'b1;
		rd(PDFS_ADDR_LOWER, 16'h1234);
		rd(PDFS_ADDR_UPPER, 16'h0);
		@(posedge mclk_i);
		manual_rst_i <= 1'b0;
		rd(8'h0c, 16'h0);
		@(posedge mclk_i);
		reset_n_i <= 1'b0;
		@(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd(PDFS_ADDR_LOWER, 16'h0);
		$display("hand tests done");
		end_sim();
	end
endmodule
`default_nettype wire
